// ### alarm_evaluator.sv
`timescale 1ns/100ps
module alarm_evaluator
  import thermal_regs_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Link to register set
  alarm_link_if.evaluator lnk
);

  evaluator_state_t cur_ff;
  evaluator_state_t nxt_state;
  logic hot;
  logic cold;
  logic [2:0] limit;
  logic [2:0] bumped;

  assign hot = $signed(lnk.sample) > $signed(lnk.upper);
  assign cold = $signed(lnk.sample) < $signed(lnk.lower);
  assign limit = fault_limit(lnk.fault_sel);
  assign bumped = cur_ff.count + 3'h1;
  assign lnk.alarm_active = (cur_ff.state == FIRED_HOT) || (cur_ff.state == FIRED_COLD);

  always_comb begin
    nxt_state = cur_ff;
    case (cur_ff.state)
      ARM_HOT: begin
        if (lnk.sample_valid) begin
          if (!hot) begin
            nxt_state.count = COUNT_ZERO;
          end else if (bumped >= limit) begin
            nxt_state.state = FIRED_HOT;
            nxt_state.count = COUNT_ZERO;
          end else begin
            nxt_state.count = bumped;
          end
        end
      end
      FIRED_HOT: begin
        if (lnk.interrupt_mode) begin
          if (lnk.clear) begin
            nxt_state.state = ARM_COLD;
            nxt_state.count = COUNT_ZERO;
          end
        end else if (lnk.sample_valid) begin
          if (!cold) begin
            nxt_state.count = COUNT_ZERO;
          end else if (bumped >= limit) begin
            nxt_state.state = ARM_HOT;
            nxt_state.count = COUNT_ZERO;
          end else begin
            nxt_state.count = bumped;
          end
        end
      end
      ARM_COLD: begin
        if (!lnk.interrupt_mode) begin
          nxt_state.state = ARM_HOT;
          nxt_state.count = COUNT_ZERO;
        end else if (lnk.sample_valid) begin
          if (!cold) begin
            nxt_state.count = COUNT_ZERO;
          end else if (bumped >= limit) begin
            nxt_state.state = FIRED_COLD;
            nxt_state.count = COUNT_ZERO;
          end else begin
            nxt_state.count = bumped;
          end
        end
      end
      FIRED_COLD: begin
        if (!lnk.interrupt_mode || lnk.clear) begin
          nxt_state.state = ARM_HOT;
          nxt_state.count = COUNT_ZERO;
        end
      end
      default: nxt_state = '{state: ARM_HOT, count: COUNT_ZERO};
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cur_ff <= '{state: ARM_HOT, count: COUNT_ZERO};
    end else begin
      cur_ff <= nxt_state;
    end
  end

  property p_fire_at_limit;
    @(posedge clk_sys_in) disable iff (rst_in)
    (cur_ff.state == ARM_HOT && lnk.sample_valid && hot && bumped == limit)
      |=> (cur_ff.state == FIRED_HOT);
  endproperty
  a_fire_at_limit: assert property (p_fire_at_limit)
    else $error("alarm did not fire at fault limit");

  property p_latched_clear;
    @(posedge clk_sys_in) disable iff (rst_in)
    (cur_ff.state == FIRED_HOT && lnk.interrupt_mode && lnk.clear)
      |=> (cur_ff.state == ARM_COLD) && !lnk.alarm_active;
  endproperty
  a_latched_clear: assert property (p_latched_clear)
    else $error("latched alarm not released by clear");

  property p_comparator_ignores_clear;
    @(posedge clk_sys_in) disable iff (rst_in)
    (cur_ff.state == FIRED_HOT && !lnk.interrupt_mode && lnk.clear && !lnk.sample_valid)
      |=> lnk.alarm_active;
  endproperty
  a_comparator_ignores_clear: assert property (p_comparator_ignores_clear)
    else $error("comparator alarm dropped by clear");

  property p_streak_breaks;
    @(posedge clk_sys_in) disable iff (rst_in)
    (cur_ff.state == ARM_HOT && lnk.sample_valid && !hot) |=> (cur_ff.count == COUNT_ZERO);
  endproperty
  a_streak_breaks: assert property (p_streak_breaks)
    else $error("fault streak not restarted");

endmodule

// ### alarm_link_if.sv
`timescale 1ns/100ps
interface alarm_link_if;
  logic sample_valid;
  logic [8:0] sample;
  logic [8:0] upper;
  logic [8:0] lower;
  logic interrupt_mode;
  logic [1:0] fault_sel;
  logic clear;
  logic alarm_active;

  modport evaluator (
    input sample_valid, sample, upper, lower, interrupt_mode, fault_sel, clear,
    output alarm_active
  );
  modport owner (
    output sample_valid, sample, upper, lower, interrupt_mode, fault_sel, clear,
    input alarm_active
  );
endinterface

// ### bus_host_model.sv
`timescale 1ns/100ps
module bus_host_model
  import thermal_regs_pkg::*;
(
  // Clock
  input wire logic clk_sys_in,
  // Register access toward the block
  output logic [1:0] reg_index_out,
  output logic write_strobe_out,
  output logic [15:0] write_data_out,
  output logic read_strobe_out,
  output logic read_cycle_active_out
);
  initial begin
    reg_index_out = 2'h0;
    write_strobe_out = 1'b0;
    write_data_out = 16'h0000;
    read_strobe_out = 1'b0;
    read_cycle_active_out = 1'b0;
  end

  task automatic wr(input logic [1:0] idx, input logic [15:0] data);
    @(posedge clk_sys_in);
    #1;
    reg_index_out = idx;
    // Host keeps the two must-be-zero settings bits clear
    write_data_out = (idx == SETTINGS_INDEX) ? (data & 16'hFF9F) : data;
    write_strobe_out = 1'b1;
    @(posedge clk_sys_in);
    #1;
    write_strobe_out = 1'b0;
    // Released data lines no longer show the last word
    write_data_out = ~write_data_out;
  endtask

  // Read cycle stays open for hold extra cycles after the strobe
  task automatic rd(input logic [1:0] idx, input int hold);
    @(posedge clk_sys_in);
    #1;
    reg_index_out = idx;
    read_strobe_out = 1'b1;
    read_cycle_active_out = 1'b1;
    @(posedge clk_sys_in);
    #1;
    read_strobe_out = 1'b0;
    repeat (hold) @(posedge clk_sys_in);
    #1;
    read_cycle_active_out = 1'b0;
  endtask
endmodule

// ### tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic clk;
  logic rst;
  logic [1:0] idx;
  logic wstb;
  logic rstb;
  logic busy;
  logic [15:0] wdat;
  logic [15:0] rdat;
  logic done;
  logic [8:0] res;
  logic en;
  logic apin;
  logic aoe;
  logic s1;
  logic s2;
  logic [15:0] exp_q[$];
  int n_mismatch;
  int n_compared;
  int n;
  logic [31:0] seed;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  thermal_sensor_register_set dut (.clk_sys_in(clk), .rst_in(rst), .reg_index_in(idx),
    .write_strobe_in(wstb), .write_data_in(wdat), .read_strobe_in(rstb),
    .read_cycle_active_in(busy), .read_data_out(rdat), .conversion_done_in(done),
    .conversion_result_in(res), .conversion_enable_out(en), .alarm_output_out(apin),
    .alarm_output_oe_out(aoe));

  bus_host_model h (.clk_sys_in(clk), .reg_index_out(idx), .write_strobe_out(wstb),
    .write_data_out(wdat), .read_strobe_out(rstb), .read_cycle_active_out(busy));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic cmp(input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic rc(input logic [1:0] i, input logic [15:0] e, input int hold);
    exp_q.push_back(e);
    h.rd(i, hold);
  endtask

  task automatic cv(input logic [8:0] r);
    @(posedge clk);
    #1;
    done = 1'b1;
    res = r;
    @(posedge clk);
    #1;
    done = 1'b0;
    res = ~r;
  endtask

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  // Open-drain pin: enable high exactly while pulling low
  task automatic pin(input logic p);
    cmp({14'h0, p, ~p}, {14'h0, apin, aoe});
  endtask

  task automatic t_end(input string s);
    $display("test %s done", s);
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Read results are due one edge after the strobe edge
  always @(posedge clk) begin
    s1 <= rstb;
    s2 <= s1;
  end
  always @(negedge clk) begin
    if (s2 === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("[FAIL] t=%0t exp=none got=%h", $time, rdat);
      end else begin
        cmp(exp_q.pop_front(), rdat);
      end
    end
  end

  initial begin
    #1000000;
    n_mismatch++;
    $display("watchdog expired");
    wrap_up();
  end

  initial begin
    rst = 1'b1;
    done = 1'b0;
    res = 9'h000;
    n_mismatch = 0;
    n_compared = 0;
    seed = 32'h5A266C3B;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    rc(2'h0, 16'h0000, 0);
    rc(2'h1, 16'h0000, 0);
    rc(2'h2, 16'h4B00, 0);
    rc(2'h3, 16'h5000, 0);
    pin(1'b1);
    t_end("reset");
    h.wr(2'h1, 16'h00FF);
    rc(2'h1, 16'h001F, 0);
    h.wr(2'h1, 16'h0000);
    h.wr(2'h0, 16'h1234);
    rc(2'h0, 16'h0000, 0);
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      h.wr(2'h2, seed[15:0]);
      // Upper read strobed in the cycle right after its write
      fork
        h.wr(2'h3, seed[31:16]);
        begin
          tick();
          rc(2'h3, seed[31:16], 0);
        end
      join
      rc(2'h2, seed[15:0], 0);
    end
    h.wr(2'h3, 16'h197F);
    h.wr(2'h2, 16'h117F);
    cv(9'h032);
    rc(2'h0, 16'h1900, 0);
    cv(9'h1CE);
    rc(2'h0, 16'hE700, 0);
    t_end("access");
    // Hot result lands while a read cycle is open
    fork
      rc(2'h0, 16'hE700, 4);
      begin
        tick();
        cv(9'h040);
      end
    join
    pin(1'b0);
    rc(2'h0, 16'hE700, 0);
    cv(9'h010);
    rc(2'h0, 16'h0800, 0);
    pin(1'b1);
    t_end("masked");
    for (int s = 0; s < 4; s++) begin
      n = (s == 0) ? 1 : 2 * s;
      h.wr(2'h1, {11'h0, s[1:0], 3'h0});
      repeat (n - 1) cv(9'h040);
      if (n > 1) begin
        cv(9'h030);
        repeat (n - 1) cv(9'h040);
      end
      tick();
      pin(1'b1);
      cv(9'h040);
      tick();
      pin(1'b0);
      repeat (n) cv(9'h022);
      tick();
      pin(1'b0);
      repeat (n - 1) cv(9'h010);
      tick();
      pin(1'b0);
      cv(9'h010);
      tick();
      pin(1'b1);
    end
    t_end("faults");
    h.wr(2'h1, 16'h0002);
    cv(9'h040);
    tick();
    pin(1'b0);
    rc(2'h3, 16'h197F, 0);
    tick();
    pin(1'b1);
    cv(9'h010);
    tick();
    pin(1'b0);
    h.wr(2'h1, 16'h0003);
    tick();
    pin(1'b1);
    cmp(16'h0001, {15'h0, en});
    rc(2'h1, 16'h0003, 0);
    cv(9'h030);
    tick();
    cmp(16'h0000, {15'h0, en});
    rc(2'h0, 16'h1800, 0);
    h.wr(2'h1, 16'h0000);
    tick();
    cmp(16'h0001, {15'h0, en});
    t_end("interrupt");
    h.wr(2'h1, 16'h0004);
    tick();
    pin(1'b0);
    cv(9'h040);
    tick();
    pin(1'b1);
    h.wr(2'h1, 16'h001C);
    tick();
    rst = 1'b1;
    tick();
    rst = 1'b0;
    rc(2'h1, 16'h0000, 0);
    rc(2'h3, 16'h5000, 0);
    pin(1'b1);
    tick();
    tick();
    t_end("polarity");
    wrap_up();
  end
endmodule

// ### thermal_regs_pkg.sv
package thermal_regs_pkg;

  // Register index as presented by the serial engine's pointer
  localparam logic [1:0] TEMP_INDEX = 2'h0;
  localparam logic [1:0] SETTINGS_INDEX = 2'h1;
  localparam logic [1:0] LOWER_INDEX = 2'h2;
  localparam logic [1:0] UPPER_INDEX = 2'h3;

  // Settings field positions
  localparam int SHUTDOWN_BIT = 0;
  localparam int MODE_BIT = 1;
  localparam int INVERT_BIT = 2;
  localparam int FAULT_LO_BIT = 3;
  localparam int FAULT_HI_BIT = 4;
  localparam int RESERVED_BIT = 7;
  localparam logic [7:0] SETTINGS_WRITE_MASK = 8'h7F;

  // Reset values
  localparam logic [7:0] SETTINGS_RESET = 8'h00;
  localparam logic [15:0] TEMP_RESET = 16'h0000;
  localparam logic [15:0] UPPER_RESET = 16'h5000;
  localparam logic [15:0] LOWER_RESET = 16'h4B00;

  // Temperature word layout
  localparam int SAMPLE_W = 9;
  localparam int SAMPLE_MSB = 15;
  localparam int SAMPLE_LSB = 7;
  localparam logic [6:0] LOW_BITS_ZERO = 7'h00;

  // Consecutive fault counts
  localparam logic [2:0] FAULTS_SEL0 = 3'h1;
  localparam logic [2:0] FAULTS_SEL1 = 3'h2;
  localparam logic [2:0] FAULTS_SEL2 = 3'h4;
  localparam logic [2:0] FAULTS_SEL3 = 3'h6;
  localparam logic [2:0] COUNT_ZERO = 3'h0;

  typedef enum logic [1:0] {ARM_HOT, FIRED_HOT, ARM_COLD, FIRED_COLD} alarm_state_t;

  typedef struct packed {
    alarm_state_t state;
    logic [2:0] count;
  } evaluator_state_t;

  typedef struct packed {
    logic [7:0] settings;
    logic [15:0] temp_word;
    logic [15:0] upper;
    logic [15:0] lower;
    logic [15:0] read_data;
    logic converting;
    logic shutdown_seen;
    logic alarm_pin;
    logic alarm_oe;
  } regs_state_t;

  function automatic logic [2:0] fault_limit(input logic [1:0] sel);
    case (sel)
      2'h0: fault_limit = FAULTS_SEL0;
      2'h1: fault_limit = FAULTS_SEL1;
      2'h2: fault_limit = FAULTS_SEL2;
      default: fault_limit = FAULTS_SEL3;
    endcase
  endfunction

  function automatic logic [SAMPLE_W-1:0] trip_sample(input logic [15:0] word);
    trip_sample = word[SAMPLE_MSB:SAMPLE_LSB];
  endfunction

  function automatic logic [15:0] temp_from_sample(input logic [SAMPLE_W-1:0] s);
    temp_from_sample = {s, LOW_BITS_ZERO};
  endfunction

endpackage

// ### thermal_sensor_register_set.sv
// Overview of operation
// - Settings bits 6..0 read and write; bit 7 reserved, reads zero.
// - Settings register volatile, all zero after every power-on.
// - Settings: shutdown bit 0, mode 1, polarity 2, fault count 3..4.
// - Mode bit 0 gives comparator alarm, 1 gives latched interrupt alarm.
// - Temperature is 16-bit read-only, refreshed on each conversion finished outside a read cycle.
// - Result always feeds alarm; readable copy updates only outside read cycles.
// - Alarm evaluation continues on every new result regardless of bus traffic.
// - During a read the old temperature is returned; later conversion updates.
// - Sign at bit 15, nine-bit value at 15..7, bits 6..0 zero.
// - Temperature register is zero at power-on.
// - Upper trip register is 16-bit read and write, temperature layout.
// - Upper trip register resets to 80 degrees.
// - Comparisons use only the nine top bits of trip registers.
// - Lower trip register is 16-bit read and write, temperature layout.
// - Lower trip register resets to 75 degrees.
// - Temperature may be read at any time without waiting.
// - Fault count selects 1, 2, 4 or 6 consecutive out-of-limit results.
// - Latched alarm released by any read or entering shutdown; a latched cold alarm also by clearing the mode bit.
// - Shutdown finishes current conversion then stops; zero resumes; bus keeps working.
`timescale 1ns/100ps
module thermal_sensor_register_set
  import thermal_regs_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Register access from the serial engine
  input wire logic [1:0] reg_index_in,
  input wire logic write_strobe_in,
  input wire logic [15:0] write_data_in,
  input wire logic read_strobe_in,
  input wire logic read_cycle_active_in,
  output logic [15:0] read_data_out,
  // Converter
  input wire logic conversion_done_in,
  input wire logic [8:0] conversion_result_in,
  output logic conversion_enable_out,
  // Alarm pin, open drain
  output logic alarm_output_out,
  output logic alarm_output_oe_out
);

  localparam regs_state_t REGS_RESET = '{
    settings: SETTINGS_RESET,
    temp_word: TEMP_RESET,
    upper: UPPER_RESET,
    lower: LOWER_RESET,
    read_data: TEMP_RESET,
    converting: 1'b1,
    shutdown_seen: 1'b0,
    alarm_pin: 1'b1,
    alarm_oe: 1'b0
  };

  regs_state_t cur_ff;
  regs_state_t nxt_regs;
  logic shutdown_entry;
  logic alarm_level;

  alarm_link_if lnk ();

  alarm_evaluator u_alarm_evaluator (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .lnk(lnk)
  );

  // Register view presented to a read
  function automatic logic [15:0] read_view(input logic [1:0] idx, input regs_state_t s);
    case (idx)
      TEMP_INDEX: read_view = s.temp_word;
      SETTINGS_INDEX: read_view = {8'h00, s.settings};
      LOWER_INDEX: read_view = s.lower;
      default: read_view = s.upper;
    endcase
  endfunction

  // Every finished result reaches the evaluator, read or not
  assign lnk.sample_valid = conversion_done_in;
  assign lnk.sample = conversion_result_in;
  assign lnk.upper = trip_sample(cur_ff.upper);
  assign lnk.lower = trip_sample(cur_ff.lower);
  assign lnk.interrupt_mode = cur_ff.settings[MODE_BIT];
  assign lnk.fault_sel = {cur_ff.settings[FAULT_HI_BIT], cur_ff.settings[FAULT_LO_BIT]};
  assign lnk.clear = read_strobe_in | shutdown_entry;

  assign alarm_level = ~(lnk.alarm_active ^ cur_ff.settings[INVERT_BIT]);

  always_comb begin
    nxt_regs = cur_ff;
    shutdown_entry = 1'b0;
    if (write_strobe_in) begin
      case (reg_index_in)
        SETTINGS_INDEX: begin
          // Reserved top bit never stored
          nxt_regs.settings = write_data_in[7:0] & SETTINGS_WRITE_MASK;
          shutdown_entry = write_data_in[SHUTDOWN_BIT] & ~cur_ff.settings[SHUTDOWN_BIT];
        end
        UPPER_INDEX: nxt_regs.upper = write_data_in;
        LOWER_INDEX: nxt_regs.lower = write_data_in;
        default: nxt_regs.temp_word = cur_ff.temp_word;
      endcase
    end
    // Readable copy frozen while a read is in flight
    if (conversion_done_in && !read_cycle_active_in) begin
      nxt_regs.temp_word = temp_from_sample(conversion_result_in);
    end
    if (read_strobe_in) begin
      nxt_regs.read_data = read_view(reg_index_in, cur_ff);
    end
    // Converter runs until the result after a shutdown request lands
    if (!cur_ff.settings[SHUTDOWN_BIT]) begin
      nxt_regs.converting = 1'b1;
    end else if (conversion_done_in) begin
      nxt_regs.converting = 1'b0;
    end
    nxt_regs.shutdown_seen = cur_ff.settings[SHUTDOWN_BIT];
    nxt_regs.alarm_pin = alarm_level;
    nxt_regs.alarm_oe = ~alarm_level;
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cur_ff <= REGS_RESET;
    end else begin
      cur_ff <= nxt_regs;
    end
  end

  assign read_data_out = cur_ff.read_data;
  assign conversion_enable_out = cur_ff.converting;
  assign alarm_output_out = cur_ff.alarm_pin;
  assign alarm_output_oe_out = cur_ff.alarm_oe;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  property p_reserved_zero;
    write_strobe_in && reg_index_in == SETTINGS_INDEX
      |=> !cur_ff.settings[RESERVED_BIT]
          && cur_ff.settings[6:0] == $past(write_data_in[6:0]);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("settings write not stored as expected");

  property p_power_on_values;
    $fell(rst_in) |-> cur_ff.settings == SETTINGS_RESET && cur_ff.temp_word == TEMP_RESET;
  endproperty
  a_power_on_values: assert property (p_power_on_values)
    else $error("settings or temperature not cleared at power-on");

  property p_trip_defaults;
    $fell(rst_in) |-> cur_ff.upper == UPPER_RESET && cur_ff.lower == LOWER_RESET;
  endproperty
  a_trip_defaults: assert property (p_trip_defaults)
    else $error("trip limits not at default after power-on");

  property p_temp_refresh;
    conversion_done_in && !read_cycle_active_in
      |=> cur_ff.temp_word == {$past(conversion_result_in), LOW_BITS_ZERO};
  endproperty
  a_temp_refresh: assert property (p_temp_refresh)
    else $error("temperature not refreshed by free conversion");

  property p_temp_masked;
    conversion_done_in && read_cycle_active_in |=> $stable(cur_ff.temp_word);
  endproperty
  a_temp_masked: assert property (p_temp_masked)
    else $error("temperature changed during a read cycle");

  property p_temp_readback;
    read_strobe_in && reg_index_in == TEMP_INDEX
      |=> read_data_out == $past(cur_ff.temp_word) && read_data_out[6:0] == LOW_BITS_ZERO;
  endproperty
  a_temp_readback: assert property (p_temp_readback)
    else $error("temperature read returned wrong word");

  property p_upper_write;
    write_strobe_in && reg_index_in == UPPER_INDEX
      ##1 read_strobe_in && reg_index_in == UPPER_INDEX
      |=> read_data_out == $past(write_data_in, 2);
  endproperty
  a_upper_write: assert property (p_upper_write)
    else $error("upper trip readback mismatch");

  property p_shutdown_stops;
    cur_ff.settings[SHUTDOWN_BIT] && conversion_done_in
      |=> !conversion_enable_out ##1 (!conversion_enable_out || !$past(cur_ff.settings[0]));
  endproperty
  a_shutdown_stops: assert property (p_shutdown_stops)
    else $error("conversion not stopped after shutdown result");

  property p_resume;
    !cur_ff.settings[SHUTDOWN_BIT] |=> conversion_enable_out;
  endproperty
  a_resume: assert property (p_resume)
    else $error("conversion not resumed after shutdown cleared");

  property p_pin_polarity;
    lnk.alarm_active && !cur_ff.settings[INVERT_BIT]
      |=> !alarm_output_out && alarm_output_oe_out;
  endproperty
  a_pin_polarity: assert property (p_pin_polarity)
    else $error("active alarm not driven low in default polarity");

  property p_shutdown_clears_latch;
    lnk.alarm_active && cur_ff.settings[MODE_BIT] && write_strobe_in
      && reg_index_in == SETTINGS_INDEX && write_data_in[SHUTDOWN_BIT]
      && write_data_in[MODE_BIT] && !cur_ff.settings[SHUTDOWN_BIT]
      |=> !lnk.alarm_active;
  endproperty
  a_shutdown_clears_latch: assert property (p_shutdown_clears_latch)
    else $error("entering shutdown did not release latched alarm");

  property p_settings_readback;
    read_strobe_in && reg_index_in == SETTINGS_INDEX
      |=> read_data_out[15:RESERVED_BIT] == 9'h000
          && read_data_out[6:0] == $past(cur_ff.settings[6:0]);
  endproperty
  a_settings_readback: assert property (p_settings_readback)
    else $error("settings read returned wrong byte");

  property p_reserved_clear;
    !cur_ff.settings[RESERVED_BIT];
  endproperty
  a_reserved_clear: assert property (p_reserved_clear)
    else $error("reserved settings bit found set");

  property p_temp_read_only;
    write_strobe_in && reg_index_in == TEMP_INDEX && !conversion_done_in
      |=> $stable(cur_ff.temp_word);
  endproperty
  a_temp_read_only: assert property (p_temp_read_only)
    else $error("write changed the temperature register");

  property p_temp_low_zero;
    cur_ff.temp_word[6:0] == LOW_BITS_ZERO;
  endproperty
  a_temp_low_zero: assert property (p_temp_low_zero)
    else $error("temperature low bits not zero");

  property p_upper_store;
    write_strobe_in && reg_index_in == UPPER_INDEX |=> cur_ff.upper == $past(write_data_in);
  endproperty
  a_upper_store: assert property (p_upper_store)
    else $error("upper trip word not stored");

  property p_lower_store;
    write_strobe_in && reg_index_in == LOWER_INDEX |=> cur_ff.lower == $past(write_data_in);
  endproperty
  a_lower_store: assert property (p_lower_store)
    else $error("lower trip word not stored");

  property p_trip_low_ignored;
    $stable(cur_ff.upper[SAMPLE_MSB:SAMPLE_LSB]) && $stable(cur_ff.lower[SAMPLE_MSB:SAMPLE_LSB])
      |-> $stable(lnk.upper) && $stable(lnk.lower);
  endproperty
  a_trip_low_ignored: assert property (p_trip_low_ignored)
    else $error("trip low bits reached the comparison");

  property p_masked_temp_hold;
    read_cycle_active_in |=> $stable(cur_ff.temp_word);
  endproperty
  a_masked_temp_hold: assert property (p_masked_temp_hold)
    else $error("temperature changed while a read was open");

  property p_read_data_stands;
    !read_strobe_in |=> $stable(read_data_out);
  endproperty
  a_read_data_stands: assert property (p_read_data_stands)
    else $error("read data changed without a read strobe");

  property p_pin_inverted;
    lnk.alarm_active && cur_ff.settings[INVERT_BIT]
      |=> alarm_output_out && !alarm_output_oe_out;
  endproperty
  a_pin_inverted: assert property (p_pin_inverted)
    else $error("active alarm not released high in inverted polarity");

  property p_pin_idle;
    !lnk.alarm_active && !cur_ff.settings[INVERT_BIT]
      |=> alarm_output_out && !alarm_output_oe_out;
  endproperty
  a_pin_idle: assert property (p_pin_idle)
    else $error("idle alarm pin not released in default polarity");

  property p_drive_only_low;
    alarm_output_oe_out != alarm_output_out;
  endproperty
  a_drive_only_low: assert property (p_drive_only_low)
    else $error("alarm pin enable does not match a low level");

  property p_shutdown_stores;
    cur_ff.settings[SHUTDOWN_BIT] && conversion_done_in && !read_cycle_active_in
      |=> cur_ff.temp_word == {$past(conversion_result_in), LOW_BITS_ZERO};
  endproperty
  a_shutdown_stores: assert property (p_shutdown_stores)
    else $error("last result before shutdown not stored");

  property p_shutdown_bus_alive;
    cur_ff.shutdown_seen && cur_ff.settings[SHUTDOWN_BIT] && read_strobe_in
      && reg_index_in == SETTINGS_INDEX |=> read_data_out[SHUTDOWN_BIT];
  endproperty
  a_shutdown_bus_alive: assert property (p_shutdown_bus_alive)
    else $error("settings read failed during shutdown");

endmodule
